// [hdl/scs_clock_select.sv]
// System clock source selector with oscillator control registers.
`timescale 1ns/10ps
module scs_clock_select #(
  parameter logic [scs_pkg::CAL_W-1:0] CAL_RESET = 7'h40, // arbitrary trim
  parameter int                        CNT_W     = 5
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic [7:0]              sfr_addr,
  input  wire logic [7:0]              sfr_wdata,
  input  wire logic                    sfr_wr,
  input  wire logic                    sfr_rd,
  output logic      [7:0]              sfr_rdata,
  input  wire logic                    hf_osc_pin,
  input  wire logic                    ext_osc_pin,
  input  wire logic                    lf_osc_pin,
  input  wire logic                    wake_external_interrupt_two_pin_pin,
  output logic                         system_clock,
  output logic                         xbar_clock,
  output logic                         ext_timer_clock,
  output logic                         hf_osc_run,
  output logic                         lf_osc_run,
  output logic [scs_pkg::CAL_W-1:0]    hf_osc_trim
);
  import scs_pkg::*;

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [N_PINS-1:0] pin_in;
  logic [N_PINS-1:0] sync1_r;
  logic [N_PINS-1:0] sync2_r;
  logic [N_PINS-1:0] sync3_r;
  assign pin_in = {wake_external_interrupt_two_pin_pin, lf_osc_pin, ext_osc_pin, hf_osc_pin};

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  scs_src_t           src_r;
  logic               crossbar_clock_output_select_r;
  logic [1:0]         hf_div_r;
  logic [1:0]         lf_div_r;
  logic               hf_en_r;
  logic               lf_en_r;
  logic               suspend_r;
  logic [CAL_W-1:0]   cal_r;
  logic               wr_sel;
  logic               wr_hfc;
  logic               wake_edge;
  logic               hf_sel;

  assign wr_sel    = sfr_wr && (sfr_addr == ADDR_CLK_SELECT);
  assign wr_hfc    = sfr_wr && (sfr_addr == ADDR_HF_CTRL);
  assign wake_edge = sync2_r[PIN_WAKE] ^ sync3_r[PIN_WAKE];
  assign hf_sel    = (src_r != SRC_EXT) && (src_r != SRC_LF);

  // A valid new code takes effect on the next edge with no ready check; reserved codes are ignored.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_r    <= scs_src_t'(RST_SRC);
      crossbar_clock_output_select_r <= 1'b0;
    end else if (wr_sel) begin
      crossbar_clock_output_select_r <= sfr_wdata[CROSSBAR_CLOCK_OUTPUT_SELECT_BIT];
      if (sfr_wdata[2:0] <= SRC_LAST_VALID) begin
        src_r <= scs_src_t'(sfr_wdata[2:0]);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hf_en_r  <= RST_HF_EN;
      hf_div_r <= RST_HF_DIV;
    end else if (wr_hfc) begin
      hf_en_r  <= sfr_wdata[HF_EN_BIT];
      hf_div_r <= sfr_wdata[1:0];
    end
  end

  // A suspend write in the same cycle as a wake edge wins.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      suspend_r <= 1'b0;
    end else if (wr_hfc && sfr_wdata[SUSPEND_BIT]) begin
      suspend_r <= 1'b1;
    end else if (wake_edge) begin
      suspend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lf_en_r  <= RST_LF_EN;
      lf_div_r <= RST_LF_DIV;
    end else if (sfr_wr && (sfr_addr == ADDR_LF_CTRL)) begin
      lf_en_r  <= sfr_wdata[LF_EN_BIT];
      lf_div_r <= sfr_wdata[1:0];
    end
  end

  // Bit 7 is dropped on write so it always reads back as zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cal_r <= CAL_RESET;
    end else if (sfr_wr && (sfr_addr == ADDR_HF_CAL)) begin
      cal_r <= sfr_wdata[CAL_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------
  logic [7:0] rd_nxt;
  always_comb begin
    case (sfr_addr)
      ADDR_CLK_SELECT: rd_nxt = {4'h0, crossbar_clock_output_select_r, src_r};
      ADDR_HF_CAL:     rd_nxt = {1'b0, cal_r};
      ADDR_HF_CTRL:    rd_nxt = {hf_en_r, hf_en_r & ~suspend_r,
                                 suspend_r, 3'h0, hf_div_r};
      ADDR_LF_CTRL:    rd_nxt = {lf_en_r, lf_en_r, 4'h0, lf_div_r};
      default:         rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Source mux and divider
  // -----------------------------------------------------------------
  scs_div_if dvi ();
  logic [2:0] shift_nxt;
  localparam int PIN_IDX_W = $clog2(N_PINS);
  logic [PIN_IDX_W-1:0] src_pin;

  always_comb begin
    case (src_r)
      SRC_HF_DIV4: shift_nxt = SHIFT_HF_DIV8 - {1'b0, hf_div_r};
      SRC_EXT:     shift_nxt = SHIFT_NONE;
      SRC_HF_DIV2: shift_nxt = SHIFT_HALF;
      SRC_HF_FULL: shift_nxt = SHIFT_NONE;
      SRC_LF:      shift_nxt = SHIFT_LF_DIV8 - {1'b0, lf_div_r};
      default:     shift_nxt = SHIFT_NONE;
    endcase
  end

  always_comb begin
    case (src_r)
      SRC_EXT: src_pin = PIN_IDX_W'(PIN_EXT);
      SRC_LF:  src_pin = PIN_IDX_W'(PIN_LF);
      default: src_pin = PIN_IDX_W'(PIN_HF);
    endcase
  end

  assign dvi.shift     = shift_nxt;
  assign dvi.src_level = sync2_r[src_pin];
  assign dvi.src_rise  = sync2_r[src_pin] & ~sync3_r[src_pin] &
                         ~(suspend_r && hf_sel);

  scs_divider #(.CNT_W(CNT_W)) u_div (
    .clk   (clk),
    .reset (reset),
    .dv    (dvi.div)
  );

  // -----------------------------------------------------------------
  // Registered outputs
  // -----------------------------------------------------------------
  logic sync_out_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      system_clock    <= 1'b0;
      sync_out_r      <= 1'b0;
      xbar_clock      <= 1'b0;
      ext_timer_clock <= 1'b0;
      hf_osc_run      <= RST_HF_EN;
      lf_osc_run      <= RST_LF_EN;
      hf_osc_trim     <= CAL_RESET;
    end else begin
      if (!(suspend_r && hf_sel)) begin
        system_clock <= dvi.clk_out;
      end
      sync_out_r      <= system_clock;
      xbar_clock      <= crossbar_clock_output_select_r ? sync_out_r : system_clock;
      ext_timer_clock <= sync2_r[PIN_EXT];
      hf_osc_run      <= hf_en_r & ~suspend_r;
      lf_osc_run      <= lf_en_r;
      hf_osc_trim     <= cal_r;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_suspend_set;
    wr_hfc && sfr_wdata[SUSPEND_BIT];
  endsequence
  sequence s_frozen;
    suspend_r && hf_sel;
  endsequence

  a_reserved_code_kept: assert property (
    (wr_sel && sfr_wdata[2:0] > SRC_LAST_VALID) |=> $stable(src_r))
    else $error("Reserved source code changed the selection.");
  a_valid_code_taken: assert property (
    (wr_sel && sfr_wdata[2:0] <= SRC_LAST_VALID)
      |=> (src_r == $past(sfr_wdata[2:0])))
    else $error("Valid source code not taken on the next edge.");
  a_top_bits_zero: assert property (
    (sfr_rd && (sfr_addr == ADDR_CLK_SELECT || sfr_addr == ADDR_HF_CAL))
      |=> (sfr_rdata[7] == 1'b0))
    else $error("Reserved top bit read back as one.");
  a_select_upper_zero: assert property (
    (sfr_rd && sfr_addr == ADDR_CLK_SELECT) |=> (sfr_rdata[6:4] == 3'h0))
    else $error("Select register bits 6:4 read nonzero.");
  a_suspend_freeze: assert property (
    s_frozen ##1 s_frozen |=> $stable(system_clock))
    else $error("System clock moved while suspended.");
  a_wake_resumes: assert property (
    (suspend_r && wake_edge && !(wr_hfc && sfr_wdata[SUSPEND_BIT]))
      |=> !suspend_r ##1 (hf_osc_run == $past(hf_en_r)))
    else $error("Wake edge did not resume the oscillator.");
  a_suspend_stops: assert property (
    s_suspend_set |=> suspend_r ##1 !hf_osc_run)
    else $error("Suspend write did not stop the oscillator.");
  a_hf_div_shift: assert property (
    (src_r == SRC_HF_DIV4) |-> (dvi.shift == 3'h5 - {1'b0, hf_div_r}))
    else $error("Wrong divide after the fixed stage.");
  a_fast_paths: assert property (
    (src_r == SRC_HF_DIV2) |-> (dvi.shift == 3'h1))
    else $error("Half-rate path has wrong divide.");
  a_xbar_raw: assert property (
    !crossbar_clock_output_select_r |=> (xbar_clock == $past(system_clock)))
    else $error("Crossbar clock not the raw system clock.");
  a_ext_timer: assert property (
    ##1 (ext_timer_clock == $past(sync2_r[PIN_EXT])))
    else $error("External timer clock not following the pin.");
  a_cal_write: assert property (
    (sfr_wr && sfr_addr == ADDR_HF_CAL)
      |=> ##1 (hf_osc_trim == $past(sfr_wdata[CAL_W-1:0], 2)))
    else $error("Calibration write did not reach the trim output.");
endmodule : scs_clock_select

// [hdl/scs_pkg.sv]
// Constants and types shared by the system clock select block.
package scs_pkg;
  // -----------------------------------------------------------------
  // Register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK_SELECT = 8'hA9;
  localparam logic [7:0] ADDR_HF_CAL     = 8'hB3;
  localparam logic [7:0] ADDR_HF_CTRL    = 8'hB2;
  localparam logic [7:0] ADDR_LF_CTRL    = 8'h86;
  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int CROSSBAR_CLOCK_OUTPUT_SELECT_BIT   = 3;
  localparam int HF_EN_BIT    = 7;
  localparam int HF_RDY_BIT   = 6;
  localparam int SUSPEND_BIT  = 5;
  localparam int LF_EN_BIT    = 7;
  localparam int CAL_W        = 7;
  // -----------------------------------------------------------------
  // Source codes and divide shifts
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_HF_DIV4 = 3'h0,
    SRC_EXT     = 3'h1,
    SRC_HF_DIV2 = 3'h2,
    SRC_HF_FULL = 3'h3,
    SRC_LF      = 3'h4
  } scs_src_t;
  localparam logic [2:0] SRC_LAST_VALID = 3'h4;
  localparam logic [2:0] SHIFT_NONE     = 3'h0;
  localparam logic [2:0] SHIFT_HALF     = 3'h1;
  localparam logic [2:0] SHIFT_HF_DIV8  = 3'h5;
  localparam logic [2:0] SHIFT_LF_DIV8  = 3'h3;
  localparam int         MAX_SHIFT      = 5;
  // -----------------------------------------------------------------
  // Reset values and pin indices
  // -----------------------------------------------------------------
  localparam logic [2:0] RST_SRC    = 3'h0;
  localparam logic [1:0] RST_HF_DIV = 2'h0;
  localparam logic [1:0] RST_LF_DIV = 2'h0;
  localparam logic       RST_HF_EN  = 1'b1;
  localparam logic       RST_LF_EN  = 1'b0;
  localparam int         N_PINS     = 4;
  localparam int         PIN_HF     = 0;
  localparam int         PIN_EXT    = 1;
  localparam int         PIN_LF     = 2;
  localparam int         PIN_WAKE   = 3;
endpackage : scs_pkg

// [hdl/scs_div_if.sv]
// Interface between the clock selector and its edge-counting divider.
`timescale 1ns/10ps
interface scs_div_if;
  logic       src_level;
  logic       src_rise;
  logic [2:0] shift;
  logic       clk_out;
  modport ctrl (output src_level, output src_rise, output shift,
                input clk_out);
  modport div  (input src_level, input src_rise, input shift,
                output clk_out);
endinterface : scs_div_if

// [hdl/scs_divider.sv]
// Power-of-two divider counting rising edges of the selected source.
`timescale 1ns/10ps
module scs_divider #(
  parameter int CNT_W = 5
) (
  input  wire logic clk,
  input  wire logic reset,
  scs_div_if.div    dv
);
  import scs_pkg::*;

  generate
    if (CNT_W < MAX_SHIFT) begin : g_bad_width
      $error("Divider counter too narrow for the longest divide.");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_r;

  // Free-running count; a source switch may give one short phase.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (dv.src_rise) begin
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_comb begin
    if (dv.shift == SHIFT_NONE) begin
      dv.clk_out = dv.src_level;
    end else begin
      dv.clk_out = cnt_r[dv.shift - 3'h1];
    end
  end
endmodule : scs_divider

// [verification/scs_osc_model.sv]
// Free-running oscillator sources seen by the clock select block.
`timescale 1ns/10ps
module scs_osc_model (
  output logic hf_osc_pin,
  output logic ext_osc_pin,
  output logic lf_osc_pin
);
  // -----------------------------------------------------------------
  // Sources
  // -----------------------------------------------------------------
  // Each source runs from time zero and never stops, so any code that the
  // bench selects is already enabled and running.
  initial begin
    hf_osc_pin  = 1'b0;
    ext_osc_pin = 1'b0;
    lf_osc_pin  = 1'b0;
  end
  always #50 hf_osc_pin = ~hf_osc_pin;
  always #100 ext_osc_pin = ~ext_osc_pin;
  always #200 lf_osc_pin = ~lf_osc_pin;
endmodule : scs_osc_model

// [verification/test_scs_clock_select.sv]
// Self-checking bench for the system clock select block.
`timescale 1ns/10ps
module test_scs_clock_select;
  import scs_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic       hf_osc_pin, ext_osc_pin, lf_osc_pin;
  logic       wake_external_interrupt_two_pin_pin = 1'b0;
  logic       system_clock, xbar_clock, ext_timer_clock;
  logic       hf_osc_run, lf_osc_run;
  logic [6:0] hf_osc_trim;
  logic [7:0] rd_val;
  logic [2:0] hist;
  int         failures = 0;
  int         num_checks = 0;
  int         sys_cnt, ext_cnt;
  // Register rows: address, write data, expected read back.
  logic [23:0] reg_rows [8] = '{24'hB2_03_03, 24'hB3_FF_7F, 24'hB3_00_00,
    24'hB2_83_C3, 24'hA9_83_03, 24'hA9_0D_0B, 24'h55_FF_00, 24'h86_82_C2};
  // Clock rows: select, hf control, lf control, system_clock rises.
  logic [31:0] clk_rows [7] = '{32'h00_80_80_05, 32'h00_83_80_28,
    32'h02_80_80_50, 32'h03_80_80_A0, 32'h01_80_80_50,
    32'h04_80_80_05, 32'h04_80_83_28};

  always #12.5 clk = ~clk;

  scs_clock_select #(.CAL_RESET(7'h2A), .CNT_W(5)) scs_clock_select_inst (
    .clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .hf_osc_pin(hf_osc_pin), .ext_osc_pin(ext_osc_pin),
    .lf_osc_pin(lf_osc_pin), .wake_external_interrupt_two_pin_pin(wake_external_interrupt_two_pin_pin),
    .system_clock(system_clock), .xbar_clock(xbar_clock),
    .ext_timer_clock(ext_timer_clock), .hf_osc_run(hf_osc_run),
    .lf_osc_run(lf_osc_run), .hf_osc_trim(hf_osc_trim));

  scs_osc_model scs_osc_model_inst (
    .hf_osc_pin(hf_osc_pin), .ext_osc_pin(ext_osc_pin),
    .lf_osc_pin(lf_osc_pin));

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr    = 1'b0;
  endtask : sfr_write

  // Read data is registered at the read edge; it is sampled one cycle on.
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd   = 1'b0;
    @(negedge clk);
    d = sfr_rdata;
  endtask : sfr_read

  task automatic count_rises(input int cycles);
    logic ps, pe;
    sys_cnt = 0;
    ext_cnt = 0;
    @(negedge clk);
    ps = system_clock;
    pe = ext_timer_clock;
    for (int i = 0; i < cycles; i++) begin
      @(negedge clk);
      if (system_clock === 1'b1 && ps === 1'b0) sys_cnt++;
      if (ext_timer_clock === 1'b1 && pe === 1'b0) ext_cnt++;
      ps = system_clock;
      pe = ext_timer_clock;
    end
  endtask : count_rises

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    check(system_clock === 1'b0 && hf_osc_run === 1'b1, "reset outputs");
    reset = 1'b0;
    sfr_read(ADDR_CLK_SELECT, rd_val);
    check(rd_val === 8'h00, "select reset value");
    sfr_read(ADDR_HF_CAL, rd_val);
    check(rd_val === 8'h2A && hf_osc_trim === 7'h2A, "trim reset");
    sfr_read(ADDR_HF_CTRL, rd_val);
    check(rd_val === 8'hC0 && hf_osc_run === 1'b1, "hf ctrl reset");
    sfr_read(ADDR_LF_CTRL, rd_val);
    check(rd_val === 8'h00 && lf_osc_run === 1'b0, "lf ctrl reset");
    count_rises(640);
    check(sys_cnt >= 4 && sys_cnt <= 6, "reset clock rate");

    // Trim is only rewritten while the hf oscillator is disabled.
    foreach (reg_rows[i]) begin
      sfr_write(reg_rows[i][23:16], reg_rows[i][15:8]);
      sfr_read(reg_rows[i][23:16], rd_val);
      check(rd_val === reg_rows[i][7:0], "register read back");
      if (reg_rows[i][23:16] == ADDR_HF_CAL)
        check(hf_osc_trim === reg_rows[i][14:8], "trim output");
      if (reg_rows[i][23:16] == ADDR_HF_CTRL)
        check(hf_osc_run === reg_rows[i][15], "hf run output");
    end
    check(lf_osc_run === 1'b1, "lf run output");

    // Enable write followed directly by the select write.
    foreach (clk_rows[i]) begin
      sfr_write(ADDR_LF_CTRL, clk_rows[i][15:8]);
      sfr_write(ADDR_HF_CTRL, clk_rows[i][23:16]);
      sfr_write(ADDR_CLK_SELECT, clk_rows[i][31:24]);
      repeat (80) @(negedge clk);
      count_rises(640);
      check(sys_cnt >= int'(clk_rows[i][7:0]) - 1 &&
            sys_cnt <= int'(clk_rows[i][7:0]) + 1,
            "system clock rate");
      check(ext_cnt >= 79 && ext_cnt <= 81, "ext timer clock");
    end

    // Crossbar output follows system_clock one or two cycles late.
    sfr_write(ADDR_HF_CTRL, 8'h83);
    for (int m = 0; m < 2; m++) begin
      sfr_write(ADDR_CLK_SELECT, m ? 8'h08 : 8'h00);
      hist = 3'b000;
      for (int i = 0; i < 64; i++) begin
        @(negedge clk);
        hist = {hist[1:0], system_clock};
        if (i > 4)
          check(xbar_clock === hist[m + 1], "crossbar clock");
      end
    end

    // Suspend freezes the hf-derived clock until an edge on the wake pin.
    sfr_write(ADDR_CLK_SELECT, 8'h00);
    sfr_write(ADDR_HF_CTRL, 8'hA3);
    repeat (3) @(negedge clk);
    check(hf_osc_run === 1'b0, "suspend stops oscillator");
    count_rises(100);
    check(sys_cnt == 0, "clock frozen in suspend");
    wake_external_interrupt_two_pin_pin = 1'b1;
    repeat (6) @(negedge clk);
    check(hf_osc_run === 1'b1, "wake restarts oscillator");
    sfr_read(ADDR_HF_CTRL, rd_val);
    check(rd_val === 8'hC3, "suspend cleared by wake");
    count_rises(640);
    check(sys_cnt >= 39 && sys_cnt <= 41, "clock resumes");

    // A mid-run reset must restore the default source, divide and trim.
    sfr_write(ADDR_CLK_SELECT, 8'h02);
    @(negedge clk);
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    sfr_read(ADDR_CLK_SELECT, rd_val);
    check(rd_val === 8'h00, "select after reset");
    sfr_read(ADDR_HF_CTRL, rd_val);
    check(rd_val === 8'hC0 && hf_osc_trim === 7'h2A, "ctrl after reset");
    count_rises(640);
    check(sys_cnt >= 4 && sys_cnt <= 6, "rate after reset");
    print_verdict();
  end
endmodule : test_scs_clock_select
